// ===== rtl/sienb_bank.sv
/*
  stage interrupt enable bank: recalibration time register, three stage
  enable registers, status banks and the polarity-selected interrupt pin.
  assumes the serial engine hands over one-cycle read and write strobes with
  a register index, and the sequencer gives one-cycle stage events and
  threshold levels, all on clk_sys_in.
*/
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module sienb_bank #(
  parameter int STAGES = sienb_pkg::STAGES
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [sienb_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [sienb_pkg::REG_W-1:0]  reg_wdata_in,
  output logic      [sienb_pkg::REG_W-1:0]  reg_rdata_out,
  input  wire logic                        irq_polarity_select_in,
  input  wire logic [STAGES-1:0]           low_exceed_in,
  input  wire logic [STAGES-1:0]           high_exceed_in,
  input  wire logic [STAGES-1:0]           stage_done_in,
  output logic      [sienb_pkg::FP_W-1:0]  full_power_recal_time_out,
  output logic      [sienb_pkg::LP_W-1:0]  low_power_recal_time_out,
  output logic                             irq_pin_out
);
  logic [sienb_pkg::FP_W-1:0]  full_power_recal_time;
  logic [sienb_pkg::LP_W-1:0]  low_power_recal_time;
  logic [sienb_pkg::REG_W-1:0] low_irq_enable;
  logic [sienb_pkg::REG_W-1:0] high_irq_enable;
  logic [sienb_pkg::REG_W-1:0] done_irq_enable;
  logic [sienb_pkg::FP_W-1:0]  next_full_power_recal_time;
  logic [sienb_pkg::LP_W-1:0]  next_low_power_recal_time;
  logic [sienb_pkg::REG_W-1:0] next_low_irq_enable;
  logic [sienb_pkg::REG_W-1:0] next_high_irq_enable;
  logic [sienb_pkg::REG_W-1:0] next_done_irq_enable;
  logic [sienb_pkg::REG_W-1:0] rdata;
  logic [sienb_pkg::REG_W-1:0] next_rdata;
  logic                        irq_pin;
  logic                        next_irq_pin;
  logic [STAGES-1:0]           low_status;
  logic [STAGES-1:0]           high_status;
  logic [STAGES-1:0]           done_status;
  logic [STAGES-1:0]           no_level;
  logic                        src_any;

  function automatic logic hit(input logic [sienb_pkg::ADDR_W-1:0] a,
                               input logic [sienb_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [sienb_pkg::REG_W-1:0] widen(input logic [STAGES-1:0] v);
    widen = sienb_pkg::ZERO_WORD;
    widen[STAGES-1:0] = v;
  endfunction : widen

  //////////////////////////////////////////////////////////////////////////////
  // status banks; completion has no lasting level
  assign no_level = '0;

  sienb_status #(.STAGES(STAGES)) u_low_status (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .event_in      (low_exceed_in),
    .level_in      (low_exceed_in),
    .read_clear_in (reg_rd_in && hit(reg_addr_in, sienb_pkg::OFS_LOW_STAT)),
    .status_out    (low_status)
  );
  sienb_status #(.STAGES(STAGES)) u_high_status (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .event_in      (high_exceed_in),
    .level_in      (high_exceed_in),
    .read_clear_in (reg_rd_in && hit(reg_addr_in, sienb_pkg::OFS_HIGH_STAT)),
    .status_out    (high_status)
  );
  sienb_status #(.STAGES(STAGES)) u_done_status (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .event_in      (stage_done_in),
    .level_in      (no_level),
    .read_clear_in (reg_rd_in && hit(reg_addr_in, sienb_pkg::OFS_DONE_STAT)),
    .status_out    (done_status)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register writes; all 16 bits stored so test and unused bits read back
  // as written, the host being trusted to keep them zero
  always_comb begin
    next_full_power_recal_time = full_power_recal_time;
    next_low_power_recal_time  = low_power_recal_time;
    next_low_irq_enable        = low_irq_enable;
    next_high_irq_enable       = high_irq_enable;
    next_done_irq_enable       = done_irq_enable;
    if (reg_wr_in) begin
      if (hit(reg_addr_in, sienb_pkg::OFS_RECAL)) begin
        next_full_power_recal_time = reg_wdata_in[sienb_pkg::FP_LSB +: sienb_pkg::FP_W];
        next_low_power_recal_time  = reg_wdata_in[sienb_pkg::LP_LSB +: sienb_pkg::LP_W];
      end
      if (hit(reg_addr_in, sienb_pkg::OFS_LOW_EN)) begin
        next_low_irq_enable = reg_wdata_in;
      end
      if (hit(reg_addr_in, sienb_pkg::OFS_HIGH_EN)) begin
        next_high_irq_enable = reg_wdata_in;
      end
      if (hit(reg_addr_in, sienb_pkg::OFS_DONE_EN)) begin
        next_done_irq_enable = reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      full_power_recal_time <= sienb_pkg::FP_RESET;
      low_power_recal_time  <= sienb_pkg::LP_RESET;
      low_irq_enable        <= sienb_pkg::ZERO_WORD;
      high_irq_enable       <= sienb_pkg::ZERO_WORD;
      done_irq_enable       <= sienb_pkg::ZERO_WORD;
    end else begin
      full_power_recal_time <= next_full_power_recal_time;
      low_power_recal_time  <= next_low_power_recal_time;
      low_irq_enable        <= next_low_irq_enable;
      high_irq_enable       <= next_high_irq_enable;
      done_irq_enable       <= next_done_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data registered one cycle after the read strobe; unmapped reads zero
  always_comb begin
    next_rdata = rdata;
    if (reg_rd_in) begin
      case (reg_addr_in)
        sienb_pkg::OFS_RECAL:     next_rdata = {low_power_recal_time, full_power_recal_time};
        sienb_pkg::OFS_LOW_EN:    next_rdata = low_irq_enable;
        sienb_pkg::OFS_HIGH_EN:   next_rdata = high_irq_enable;
        sienb_pkg::OFS_DONE_EN:   next_rdata = done_irq_enable;
        sienb_pkg::OFS_LOW_STAT:  next_rdata = widen(low_status);
        sienb_pkg::OFS_HIGH_STAT: next_rdata = widen(high_status);
        sienb_pkg::OFS_DONE_STAT: next_rdata = widen(done_status);
        default:                  next_rdata = sienb_pkg::ZERO_WORD;
      endcase
    end
  end

  // pin registered so it comes glitch free from a flip-flop
  always_comb begin
    next_irq_pin = |((low_status  & low_irq_enable[STAGES-1:0])  |
                     (high_status & high_irq_enable[STAGES-1:0]) |
                     (done_status & done_irq_enable[STAGES-1:0]));
    next_irq_pin = irq_polarity_select_in ? next_irq_pin : !next_irq_pin;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata   <= sienb_pkg::ZERO_WORD;
      irq_pin <= 1'b1;
    end else begin
      rdata   <= next_rdata;
      irq_pin <= next_irq_pin;
    end
  end

  assign reg_rdata_out             = rdata;
  assign irq_pin_out               = irq_pin;
  assign full_power_recal_time_out = full_power_recal_time;
  assign low_power_recal_time_out  = low_power_recal_time;

  // any enabled source, watched only by the checks below
  assign src_any = |((low_status  & low_irq_enable[STAGES-1:0])  |
                     (high_status & high_irq_enable[STAGES-1:0]) |
                     (done_status & done_irq_enable[STAGES-1:0]));

  //////////////////////////////////////////////////////////////////////////////
  // the pin is one register behind, so it follows the polarity of the cycle before
  sequence s_recal_write;
    reg_wr_in && hit(reg_addr_in, sienb_pkg::OFS_RECAL);
  endsequence
  sequence s_high_write;
    reg_wr_in && hit(reg_addr_in, sienb_pkg::OFS_HIGH_EN);
  endsequence
  sequence s_high_read;
    reg_rd_in && hit(reg_addr_in, sienb_pkg::OFS_HIGH_EN) && !reg_wr_in;
  endsequence
  property p_recal_fp;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    s_recal_write |=> full_power_recal_time_out == $past(reg_wdata_in[9:0]);
  endproperty
  a_recal_fp: assert property (p_recal_fp) else $error("full power time not stored");
  property p_recal_lp;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    s_recal_write |=> low_power_recal_time_out == $past(reg_wdata_in[15:10]);
  endproperty
  a_recal_lp: assert property (p_recal_lp) else $error("low power time not stored");
  property p_low_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (|(low_status & low_irq_enable[STAGES-1:0]))
    |=> irq_pin_out == $past(irq_polarity_select_in);
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low source did not raise pin");
  property p_high_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (|(high_status & high_irq_enable[STAGES-1:0]))
    |=> irq_pin_out == $past(irq_polarity_select_in);
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("high source did not raise pin");
  property p_done_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (|(done_status & done_irq_enable[STAGES-1:0]))
    |=> irq_pin_out == $past(irq_polarity_select_in);
  endproperty
  a_done_gate: assert property (p_done_gate) else $error("done source did not raise pin");
  property p_readback;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    s_high_write ##1 s_high_read |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("enable readback mismatch");
  property p_quiet;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !src_any |=> irq_pin_out == !$past(irq_polarity_select_in);
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin active with no source");
  property p_polarity;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $changed(irq_polarity_select_in) && $stable(src_any) |=> $changed(irq_pin_out);
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin did not follow polarity");
endmodule : sienb_bank
`default_nettype wire

// ===== common/sienb_pkg.sv
/*
  constants for the stage interrupt enable bank: register indices, field
  positions, reset values and status bank codes.
  assumes a 16-bit register word reached by a plain index on the device side.
*/
`default_nettype none
package sienb_pkg;
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 8;
  localparam int          STAGES        = 8;
  localparam logic [7:0]  OFS_RECAL     = 8'h04;
  localparam logic [7:0]  OFS_LOW_EN    = 8'h05;
  localparam logic [7:0]  OFS_HIGH_EN   = 8'h06;
  localparam logic [7:0]  OFS_DONE_EN   = 8'h07;
  localparam logic [7:0]  OFS_LOW_STAT  = 8'h08;
  localparam logic [7:0]  OFS_HIGH_STAT = 8'h09;
  localparam logic [7:0]  OFS_DONE_STAT = 8'h0A;
  localparam int          FP_LSB        = 0;
  localparam int          FP_W          = 10;
  localparam int          LP_LSB        = 10;
  localparam int          LP_W          = 6;
  localparam logic [9:0]  FP_RESET      = 10'h3FF;
  localparam logic [5:0]  LP_RESET      = 6'h3F;
  localparam logic [7:0]  EN_RESET      = 8'h00;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  typedef enum logic [1:0] {
    SIENB_BANK_LOW  = 2'b00,
    SIENB_BANK_HIGH = 2'b01,
    SIENB_BANK_DONE = 2'b10
  } sienb_bank_t;
endpackage : sienb_pkg
`default_nettype wire

// ===== rtl/sienb_status.sv
/*
  one bank of eight sticky stage status bits with clear on read.
  assumes event and level inputs already synchronous to clk_sys_in.
*/
`default_nettype none
module sienb_status #(
  parameter int STAGES = 8
) (
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  input  wire logic [STAGES-1:0] event_in,
  input  wire logic [STAGES-1:0] level_in,
  input  wire logic              read_clear_in,
  output logic      [STAGES-1:0] status_out
);
  logic [STAGES-1:0] status;
  logic [STAGES-1:0] next_status;

  // a new event beats the read clear; a held level keeps the bit set
  always_comb begin
    next_status = status;
    if (read_clear_in) begin
      next_status = level_in;
    end
    next_status = next_status | event_in | level_in;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign status_out = status;

  property p_read_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    read_clear_in && !(|event_in) && !(|level_in) |=> status_out == '0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared on read");
  property p_sticky;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !read_clear_in |=> (status_out & $past(status_out)) == $past(status_out);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost without read");
endmodule : sienb_status
`default_nettype wire

// ===== sim/sienb_host_model.sv
/*
  host-side partner: turns the interrupt pin into an active flag.
  assumes the host knows the polarity select level set in the device.
*/
`default_nettype none
module sienb_host_model (
  input  wire logic irq_pin_in,
  input  wire logic irq_polarity_select_in,
  output logic      irq_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // an unknown pin level never reads as active
  assign irq_active_out = (irq_pin_in === irq_polarity_select_in);
endmodule : sienb_host_model
`default_nettype wire

// ===== sim/tb_stage_interrupt_enable_bank.sv
/*
  self-checking bench for the stage interrupt enable bank.
  assumes one-cycle register strobes and the host model on the pin.
*/
`default_nettype none
module tb_stage_interrupt_enable_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        reg_wr_in  = 1'b0;
  logic        reg_rd_in  = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        pol = 1'b0;
  logic [7:0]  low_in = 8'h00;
  logic [7:0]  high_in = 8'h00;
  logic [7:0]  done_in = 8'h00;
  logic [15:0] reg_rdata_out;
  logic [9:0]  fp_out;
  logic [5:0]  lp_out;
  logic        pin_out;
  logic        act;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  sienb_bank u_sienb_bank (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .irq_polarity_select_in(pol), .low_exceed_in(low_in), .high_exceed_in(high_in),
    .stage_done_in(done_in), .full_power_recal_time_out(fp_out),
    .low_power_recal_time_out(lp_out), .irq_pin_out(pin_out));
  sienb_host_model u_sienb_host_model (.irq_pin_in(pin_out),
    .irq_polarity_select_in(pol), .irq_active_out(act));
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rd
  // write then read on the very next edge, the tightest order allowed
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, d);
  endtask : wr_rd
  task automatic pin_is(input logic exp);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({15'h0000, act}, {15'h0000, exp});
  endtask : pin_is
  // level sources are pulsed here; held levels get their own test
  task automatic src_test(input logic [1:0] k, input logic [2:0] b, input logic en);
    wr(8'h05 + {6'h00, k}, {8'h00, en ? 8'h01 << b : 8'h00});
    @(posedge clk_sys_in);
    if (k == 2'd0) low_in <= 8'h01 << b;
    if (k == 2'd1) high_in <= 8'h01 << b;
    if (k == 2'd2) done_in <= 8'h01 << b;
    @(posedge clk_sys_in);
    low_in  <= 8'h00;
    high_in <= 8'h00;
    done_in <= 8'h00;
    pin_is(en);
    rd(8'h08 + {6'h00, k}, 16'h0001 << b);
    pin_is(1'b0);
    $display("source %0d stage %0d enable %0d done", k, b, en);
  endtask : src_test
  task automatic reset_test();
    chk({6'h00, fp_out}, 16'h03FF);
    chk({10'h000, lp_out}, 16'h003F);
    rd(8'h04, 16'hFFFF);
    for (int i = 5; i < 8; i++) rd(8'(i), 16'h0000);
    chk({15'h0000, pin_out}, 16'h0001);
    $display("reset test done");
  endtask : reset_test
  task automatic map_test();
    wr(8'h04, 16'hA5C3);
    #1;
    chk({6'h00, fp_out}, 16'h01C3);
    chk({10'h000, lp_out}, 16'h0029);
    rd(8'h04, 16'hA5C3);
    wr(8'h05, 16'h00A5);
    wr(8'h06, 16'h005A);
    wr(8'h07, 16'h0081);
    rd(8'h05, 16'h00A5);
    rd(8'h06, 16'h005A);
    rd(8'h07, 16'h0081);
    wr_rd(8'h06, 16'h00C3);
    for (int i = 5; i < 8; i++) wr(8'(i), 16'h0000);
    wr(8'h03, 16'h1234);
    rd(8'h03, 16'h0000);
    wr(8'h08, 16'h00FF);
    rd(8'h08, 16'h0000);
    $display("register map test done");
  endtask : map_test
  task automatic level_test();
    wr(8'h05, 16'h0008);
    @(posedge clk_sys_in);
    low_in <= 8'h08;
    rd(8'h08, 16'h0008);
    rd(8'h08, 16'h0008);
    pin_is(1'b1);
    @(posedge clk_sys_in);
    low_in <= 8'h00;
    rd(8'h08, 16'h0008);
    rd(8'h08, 16'h0000);
    pin_is(1'b0);
    wr(8'h05, 16'h0000);
    $display("held level test done");
  endtask : level_test
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    reset_test();
    map_test();
    for (int k = 0; k < 3; k++) begin
      src_test(2'(k), 3'd0, 1'b1);
      src_test(2'(k), 3'd7, 1'b1);
      src_test(2'(k), 3'd4, 1'b0);
    end
    level_test();
    @(posedge clk_sys_in);
    pol <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({15'h0000, pin_out}, 16'h0000);
    src_test(2'd2, 3'd5, 1'b1);
    close_out();
  end
endmodule : tb_stage_interrupt_enable_bank
`default_nettype wire
